/* File: hdl/dtc_edge.sv */
// Purpose: Falling-edge detector for a timer count pin.
// Assumes: Pin is synchronous to clk.
// Notes:   Idle level is high so a low pin at reset counts once.
`timescale 1ns/1ps
module dtc_edge (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic ce,
	input  wire logic level,
	output logic      fall
);
	logic prev_q;  // Level seen on the last enabled cycle

	// High-to-low between two enabled samples
	assign fall = ce && prev_q && !level;

	// Sample only while enabled so a freeze holds the edge state
	always_ff @(posedge clk) begin
		if (!rstn) begin
			prev_q <= dtc_pkg::PIN_IDLE;
		end else if (ce) begin
			prev_q <= level;
		end
	end
endmodule

/* File: hdl/dtc_pkg.sv */
// Purpose: Shared constants of the dual timer/counter block.
// Assumes: 8-bit register port, one system clock.
// Notes:   Offsets are register port addresses.
//
// Function
// - Split mode: first low byte independent 8-bit
// - Split high byte: system clock, second run
// - Split: second timer never sets its flag
// - Split: second timer system clock, no gate
// - Split: second timer runs unless mode 3
// - Flags set on overflow; written one interrupts
// - Run bits start and stop timers
// - Gate bit needs external pin high
// - Source select: system clock or pin
// - Mode field picks 13, 16, reload, split
// - All registers clear on reset
// - Prescale select: divide by twelve or not
// - Toggle enable drives pin, inverts on overflow; logic does so only in timer operation
// - Counter mode counts pin falling edges
// - Reload low byte from high byte
// - Run bit never clears the count
package dtc_pkg;
	// Register port addresses
	localparam logic [7:0] ADDR_CTRL = 8'h88;
	localparam logic [7:0] ADDR_MODE = 8'h89;
	localparam logic [7:0] ADDR_TL0  = 8'h8a;
	localparam logic [7:0] ADDR_TL1  = 8'h8b;
	localparam logic [7:0] ADDR_TH0  = 8'h8c;
	localparam logic [7:0] ADDR_TH1  = 8'h8d;
	localparam logic [7:0] ADDR_PTC  = 8'hce;
	localparam logic [7:0] ADDR_STS  = 8'hd0;
	localparam logic [7:0] ADDR_MSK  = 8'hd1;
	// Control register bits
	localparam int CT_TF1 = 7;
	localparam int CT_TR1 = 6;
	localparam int CT_TF0 = 5;
	localparam int CT_TR0 = 4;
	// Mode register bits
	localparam int MD_SECOND_GATE_BIT = 7;
	localparam int MD_SRC1  = 6;
	localparam int MD_M1_HI = 5;
	localparam int MD_M1_LO = 4;
	localparam int MD_FIRST_GATE_BIT = 3;
	localparam int MD_SRC0  = 2;
	localparam int MD_M0_HI = 1;
	localparam int MD_M0_LO = 0;
	// Prescale/toggle bits
	localparam int PT_PRE1 = 3;
	localparam int PT_PRE0 = 2;
	localparam int PT_TOG1 = 1;
	localparam int PT_TOG0 = 0;
	localparam int PT_W    = 4;
	// Interrupt status bits
	localparam int ST_OVF0 = 0;
	localparam int ST_OVF1 = 1;
	localparam int ST_W    = 2;
	// Timer modes
	typedef enum logic [1:0] {
		DTC_M13    = 2'h0,
		DTC_M16    = 2'h1,
		DTC_RELOAD = 2'h2,
		DTC_SPLIT  = 2'h3
	} dtc_mode_t;
	// Values
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_MAX  = 8'hff;
	localparam logic [7:0] BYTE_ONE  = 8'h01;
	localparam logic       PIN_IDLE  = 1'b1;
	localparam int         PRESCALE_DIV = 12;
endpackage

/* File: hdl/dtc_prescale.sv */
// Purpose: Free divider giving one tick every DIV enabled cycles.
// Assumes: Shared by both timers; each timer picks it or not.
// Notes:   Counter is frozen while ce is low.
`timescale 1ns/1ps
module dtc_prescale #(
	parameter int DIV = dtc_pkg::PRESCALE_DIV
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	dtc_tick_if.src  tk
);
	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	localparam logic [CW-1:0] ONE  = CW'(1);

	generate
		if (DIV < 2) begin : g_chk
			$error("dtc_prescale: DIV must be at least two");
		end
	endgenerate

	logic [CW-1:0] cnt_q;  // Cycle position within one period

	// Tick only on an enabled cycle so a frozen block sees none
	assign tk.tick = ce && (cnt_q == LAST);

	// Wraps at LAST; cleared by reset
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt_q <= '0;
		end else if (ce) begin
			cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + ONE;
		end
	end
endmodule

/* File: hdl/dtc_tick_if.sv */
// Purpose: Carries the divided clock tick between block modules.
// Assumes: Tick is a one-cycle pulse, already gated by clock enable.
// Notes:   Source is the prescaler, sink is the timer core.
`timescale 1ns/1ps
interface dtc_tick_if;
	logic tick;     // Divided clock pulse
	modport src (output tick);
	modport snk (input tick);
endinterface

/* File: hdl/dtc_top.sv */
// Purpose: Two 16-bit timer/counters with first-timer split mode.
// Assumes: Register port with read data one cycle after strobe.
// Notes:   Software write of a count byte wins over counting.
`timescale 1ns/1ps
module dtc_top #(
	parameter int DIV = dtc_pkg::PRESCALE_DIV
) (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       ce,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	input  wire logic       first_timer_pin,
	output logic            first_pin_drive,
	output logic            first_pin_drive_en,
	input  wire logic       second_timer_pin,
	output logic            second_pin_drive,
	output logic            second_pin_drive_en,
	output logic            second_pin_pullup_en,
	input  wire logic [1:0] external_interrupt_pin,
	output logic [1:0]      external_request_flag,
	output logic [1:0]      external_trigger_select,
	output logic            first_timer_irq,
	output logic            second_timer_irq,
	output logic            baud_tick,
	output logic            irq
);
	generate
		if (DIV < 2) begin : g_chk
			$error("dtc_top: DIV must be at least two");
		end
	endgenerate

	logic [7:0] ctrl_q;      // Control register
	logic [7:0] mode_q;      // Mode register
	logic [7:0] tl0_q;       // First count low
	logic [7:0] th0_q;       // First count high
	logic [7:0] tl1_q;       // Second count low
	logic [7:0] th1_q;       // Second count high
	logic [3:0] ptc_q;       // Prescale/toggle bits
	logic [1:0] sts_q;       // Sticky overflow events
	logic [1:0] msk_q;       // Interrupt mask
	logic [7:0] rdata_q;     // Read data register
	logic       pin0_q;      // First pin toggle level
	logic       pin1_q;      // Second pin toggle level
	logic       baud_q;      // Registered baud pulse

	// Shared divide-by-DIV tick
	dtc_tick_if u_tick ();
	dtc_prescale #(.DIV(DIV)) u_pre (
		.clk  (clk),
		.rstn (rstn),
		.ce   (ce),
		.tk   (u_tick.src)
	);

	logic fall0;  // First pin falling edge
	logic fall1;  // Second pin falling edge
	dtc_edge u_edge0 (
		.clk   (clk),
		.rstn  (rstn),
		.ce    (ce),
		.level (first_timer_pin),
		.fall  (fall0)
	);
	dtc_edge u_edge1 (
		.clk   (clk),
		.rstn  (rstn),
		.ce    (ce),
		.level (second_timer_pin),
		.fall  (fall1)
	);

	// Address decode
	logic wr_ctrl, wr_mode, wr_tl0, wr_th0, wr_tl1, wr_th1, wr_ptc;
	logic wr_msk, rd_sts;
	always_comb begin
		wr_ctrl = 1'b0;
		wr_mode = 1'b0;
		wr_tl0  = 1'b0;
		wr_th0  = 1'b0;
		wr_tl1  = 1'b0;
		wr_th1  = 1'b0;
		wr_ptc  = 1'b0;
		wr_msk  = 1'b0;
		if (reg_addr == dtc_pkg::ADDR_CTRL) begin
			wr_ctrl = reg_wr;
		end else if (reg_addr == dtc_pkg::ADDR_MODE) begin
			wr_mode = reg_wr;
		end else if (reg_addr == dtc_pkg::ADDR_TL0) begin
			wr_tl0 = reg_wr;
		end else if (reg_addr == dtc_pkg::ADDR_TH0) begin
			wr_th0 = reg_wr;
		end else if (reg_addr == dtc_pkg::ADDR_TL1) begin
			wr_tl1 = reg_wr;
		end else if (reg_addr == dtc_pkg::ADDR_TH1) begin
			wr_th1 = reg_wr;
		end else if (reg_addr == dtc_pkg::ADDR_PTC) begin
			wr_ptc = reg_wr;
		end else if (reg_addr == dtc_pkg::ADDR_MSK) begin
			wr_msk = reg_wr;
		end
		// Unmapped writes are dropped
	end
	assign rd_sts = reg_rd && (reg_addr == dtc_pkg::ADDR_STS);

	// Field views
	logic      tr0, tr1, first_gate_bit, second_gate_bit, src0, src1, split;
	logic [1:0] m0, m1;
	assign tr0   = ctrl_q[dtc_pkg::CT_TR0];
	assign tr1   = ctrl_q[dtc_pkg::CT_TR1];
	assign first_gate_bit = mode_q[dtc_pkg::MD_FIRST_GATE_BIT];
	assign second_gate_bit = mode_q[dtc_pkg::MD_SECOND_GATE_BIT];
	assign src0  = mode_q[dtc_pkg::MD_SRC0];
	assign src1  = mode_q[dtc_pkg::MD_SRC1];
	assign m0    = mode_q[dtc_pkg::MD_M0_HI:dtc_pkg::MD_M0_LO];
	assign m1    = mode_q[dtc_pkg::MD_M1_HI:dtc_pkg::MD_M1_LO];
	assign split = (m0 == dtc_pkg::DTC_SPLIT);

	// One increment of a count pair; returns {overflow, high, low}
	function automatic logic [16:0] step(input logic [1:0] m,
		input logic [7:0] lo, input logic [7:0] hi);
		logic [13:0] s13;
		logic [16:0] s16;
		logic [8:0]  s8;
		s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
		s16 = {1'b0, hi, lo} + 17'h00001;
		s8  = {1'b0, lo} + 9'h001;
		case (m)
			// Low bits 7..5 are left alone
			dtc_pkg::DTC_M13: begin
				step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
			end
			dtc_pkg::DTC_M16: begin
				step = s16;
			end
			// Wrap past the top reloads from high, high kept
			dtc_pkg::DTC_RELOAD: begin
				step = {s8[8], hi, s8[8] ? hi : s8[7:0]};
			end
			// Low byte alone, high untouched
			default: begin
				step = {s8[8], hi, s8[7:0]};
			end
		endcase
	endfunction

	// Clock source per timer: undivided or the divided tick
	logic tick0, tick1;
	assign tick0 = ce && (ptc_q[dtc_pkg::PT_PRE0] || u_tick.snk.tick);
	assign tick1 = ce && (ptc_q[dtc_pkg::PT_PRE1] || u_tick.snk.tick);

	// First timer enable and increment
	logic run0, inc0, ovf0;
	logic [16:0] nx0;
	assign run0 = tr0 && (!first_gate_bit || external_interrupt_pin[0]);
	assign inc0 = run0 && (src0 ? fall0 : tick0);
	assign nx0  = step(m0, tl0_q, th0_q);
	assign ovf0 = inc0 && nx0[16];

	// Split high byte: system clock only, run by second run bit
	logic inc_h, ovf_h;
	assign inc_h = split && tr1 && tick0;
	assign ovf_h = inc_h && (th0_q == dtc_pkg::BYTE_MAX);

	// Second timer; in split it ignores gate, pin and run bit
	logic run1, inc1, ovf1;
	logic [16:0] nx1;
	always_comb begin
		if (split) begin
			run1 = (m1 != dtc_pkg::DTC_SPLIT);
		end else begin
			// Mode 3, like a clear run bit or a low gated pin, holds the second timer
			run1 = tr1 && (!second_gate_bit || external_interrupt_pin[1]) &&
				(m1 != dtc_pkg::DTC_SPLIT);
		end
	end
	assign inc1 = run1 && ((src1 && !split) ? fall1 : tick1);
	assign nx1  = step(m1, tl1_q, th1_q);
	assign ovf1 = inc1 && nx1[16];

	// Flag set events; split hides the second timer's own overflow
	logic set0, set1;
	assign set0 = ovf0;
	assign set1 = ovf_h || (ovf1 && !split);

	// Control register: set by hardware wins over software clear
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctrl_q <= dtc_pkg::BYTE_ZERO;
		end else if (ce) begin
			if (wr_ctrl) begin
				ctrl_q <= reg_wdata;
			end
			if (set0) begin
				ctrl_q[dtc_pkg::CT_TF0] <= 1'b1;
			end
			if (set1) begin
				ctrl_q[dtc_pkg::CT_TF1] <= 1'b1;
			end
		end
	end

	// Mode and prescale/toggle registers
	always_ff @(posedge clk) begin
		if (!rstn) begin
			mode_q <= dtc_pkg::BYTE_ZERO;
			ptc_q  <= '0;
		end else if (ce) begin
			if (wr_mode) begin
				mode_q <= reg_wdata;
			end
			if (wr_ptc) begin
				ptc_q <= reg_wdata[dtc_pkg::PT_W-1:0];
			end
		end
	end

	// First count bytes; counts resume where they stopped
	always_ff @(posedge clk) begin
		if (!rstn) begin
			tl0_q <= dtc_pkg::BYTE_ZERO;
			th0_q <= dtc_pkg::BYTE_ZERO;
		end else if (ce) begin
			if (wr_tl0) begin
				tl0_q <= reg_wdata;
			end else if (inc0) begin
				tl0_q <= nx0[7:0];
			end
			if (wr_th0) begin
				th0_q <= reg_wdata;
			end else if (inc_h) begin
				th0_q <= th0_q + dtc_pkg::BYTE_ONE;
			end else if (inc0 && !split) begin
				th0_q <= nx0[15:8];
			end
		end
	end

	// Second count bytes; a port write here upsets baud timing
	always_ff @(posedge clk) begin
		if (!rstn) begin
			tl1_q <= dtc_pkg::BYTE_ZERO;
			th1_q <= dtc_pkg::BYTE_ZERO;
		end else if (ce) begin
			if (wr_tl1) begin
				tl1_q <= reg_wdata;
			end else if (inc1) begin
				tl1_q <= nx1[7:0];
			end
			if (wr_th1) begin
				th1_q <= reg_wdata;
			end else if (inc1) begin
				th1_q <= nx1[15:8];
			end
		end
	end

	// Toggle outputs: only while in timer operation
	logic tog0, tog1;
	assign tog0 = ptc_q[dtc_pkg::PT_TOG0] && !src0;
	assign tog1 = ptc_q[dtc_pkg::PT_TOG1] && (!src1 || split);
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pin0_q <= 1'b0;
			pin1_q <= 1'b0;
		end else if (ce) begin
			if (tog0 && ovf0) begin
				pin0_q <= !pin0_q;
			end
			if (tog1 && ovf1) begin
				pin1_q <= !pin1_q;
			end
		end
	end

	// Baud pulse survives split mode, unlike the flag
	always_ff @(posedge clk) begin
		if (!rstn) begin
			baud_q <= 1'b0;
		end else if (ce) begin
			baud_q <= ovf1;
		end
	end

	// Sticky status: an event in the read cycle is kept
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sts_q <= '0;
			msk_q <= '0;
		end else if (ce) begin
			if (rd_sts) begin
				sts_q <= '0;
			end
			if (set0) begin
				sts_q[dtc_pkg::ST_OVF0] <= 1'b1;
			end
			if (set1) begin
				sts_q[dtc_pkg::ST_OVF1] <= 1'b1;
			end
			if (wr_msk) begin
				msk_q <= reg_wdata[dtc_pkg::ST_W-1:0];
			end
		end
	end

	// Read data: valid only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata_q <= dtc_pkg::BYTE_ZERO;
		end else if (ce) begin
			if (!reg_rd) begin
				rdata_q <= dtc_pkg::BYTE_ZERO;
			end else if (reg_addr == dtc_pkg::ADDR_CTRL) begin
				rdata_q <= ctrl_q;
			end else if (reg_addr == dtc_pkg::ADDR_MODE) begin
				rdata_q <= mode_q;
			end else if (reg_addr == dtc_pkg::ADDR_TL0) begin
				rdata_q <= tl0_q;
			end else if (reg_addr == dtc_pkg::ADDR_TH0) begin
				rdata_q <= th0_q;
			end else if (reg_addr == dtc_pkg::ADDR_TL1) begin
				rdata_q <= tl1_q;
			end else if (reg_addr == dtc_pkg::ADDR_TH1) begin
				rdata_q <= th1_q;
			end else if (reg_addr == dtc_pkg::ADDR_PTC) begin
				rdata_q <= {4'h0, ptc_q};
			end else if (reg_addr == dtc_pkg::ADDR_STS) begin
				rdata_q <= {6'h00, sts_q};
			end else if (reg_addr == dtc_pkg::ADDR_MSK) begin
				rdata_q <= {6'h00, msk_q};
			end else begin
				rdata_q <= dtc_pkg::BYTE_ZERO;  // Unmapped reads zero
			end
		end
	end

	// Outputs
	assign reg_rdata            = rdata_q;
	assign first_pin_drive      = pin0_q;
	assign first_pin_drive_en   = tog0;
	assign second_pin_drive     = pin1_q;
	assign second_pin_drive_en  = tog1;
	assign second_pin_pullup_en = !split;
	assign external_request_flag   = {ctrl_q[3], ctrl_q[1]};
	assign external_trigger_select = {ctrl_q[2], ctrl_q[0]};
	// Flags are the timer interrupt requests, so a written one fires
	assign first_timer_irq  = ctrl_q[dtc_pkg::CT_TF0];
	assign second_timer_irq = ctrl_q[dtc_pkg::CT_TF1];
	assign baud_tick = baud_q;
	assign irq       = |(sts_q & msk_q);

	// Checks
	property p_split_high;
		@(posedge clk) disable iff (!rstn)
		(inc_h && !wr_th0) |=> (th0_q == $past(th0_q) + dtc_pkg::BYTE_ONE);
	endproperty
	a_split_high: assert property (p_split_high)
		else $error("split high byte did not step");

	property p_split_noflag;
		@(posedge clk) disable iff (!rstn)
		(ce && split && !ovf_h && !wr_ctrl && !second_timer_irq)
		|=> !second_timer_irq;
	endproperty
	a_split_noflag: assert property (p_split_noflag)
		else $error("second flag set during split");

	property p_split_stop;
		@(posedge clk) disable iff (!rstn)
		(split && m1 == dtc_pkg::DTC_SPLIT && !wr_tl1) |=> $stable(tl1_q);
	endproperty
	a_split_stop: assert property (p_split_stop)
		else $error("second timer ran in mode 3");

	property p_run_stop;
		@(posedge clk) disable iff (!rstn)
		(!tr0 && !wr_tl0) |=> $stable(tl0_q);
	endproperty
	a_run_stop: assert property (p_run_stop)
		else $error("first timer counted while stopped");

	property p_gate;
		@(posedge clk) disable iff (!rstn)
		(first_gate_bit && !external_interrupt_pin[0] && !wr_tl0) |=> $stable(tl0_q);
	endproperty
	a_gate: assert property (p_gate)
		else $error("gated timer counted with pin low");

	property p_reload;
		@(posedge clk) disable iff (!rstn)
		(ovf0 && m0 == dtc_pkg::DTC_RELOAD && !wr_tl0)
		|=> (tl0_q == $past(th0_q)) && first_timer_irq;
	endproperty
	a_reload: assert property (p_reload)
		else $error("reload or flag missing");

	property p_flag_set;
		@(posedge clk) disable iff (!rstn)
		ovf0 |=> first_timer_irq ##1 (first_timer_irq || $past(wr_ctrl));
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("first flag not set on overflow");

	property p_toggle;
		@(posedge clk) disable iff (!rstn)
		(tog0 && ovf0) |=> (first_pin_drive != $past(first_pin_drive));
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("first pin did not toggle");

	property p_read;
		@(posedge clk) disable iff (!rstn)
		(ce && reg_rd && reg_addr == dtc_pkg::ADDR_MODE)
		|=> (reg_rdata == $past(mode_q)) ##1 (reg_rdata == 8'h00 ||
		$past(reg_rd));
	endproperty
	a_read: assert property (p_read)
		else $error("mode read data wrong");
endmodule

/* File: verif/dtc_cpu_model.sv */
// Purpose: Processor core model that owns the register port.
// Assumes: One access per task call; strobes last one cycle.
// Notes:   Read data is taken in the cycle after the read edge.
`timescale 1ns/1ps
module dtc_cpu_model (
	input  wire logic       clk,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	// Idle bus from time zero so reset sees no strobe
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// Single-cycle write; the small step lets register updates land
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	// Single-cycle read; data only stands in the following cycle
	// Second count bytes are only read here once that timer is
	// stopped, so the baud clock is never disturbed
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
endmodule

/* File: verif/testbench.sv */
// Purpose: Self-checking bench for the dual timer/counter block.
// Assumes: Core model issues every register access.
// Notes:   Count rates are taken as deltas over fixed cycle spans.
`timescale 1ns/1ps
module testbench;
	localparam int DIV = 12;    // Prescale ratio handed to the design
	localparam int LIMIT = 20000; // Cycle ceiling for the whole run
	logic       clk;            // System clock
	logic       rstn;           // Active low reset
	logic [7:0] reg_addr;       // Register address
	logic [7:0] reg_wdata;      // Register write data
	logic       reg_wr;         // Write strobe
	logic       reg_rd;         // Read strobe
	logic [7:0] reg_rdata;      // Register read data
	logic       pin0;           // First timer count pin
	logic       pin1;           // Second timer count pin
	logic [1:0] gate_pins;      // External gate pins
	logic       drv0;           // First pin output level
	logic       drv0_en;        // First pin output enable
	logic       drv1;           // Second pin output level
	logic       drv1_en;        // Second pin output enable
	logic       ce;             // Clock enable, low freezes the design
	logic       pullup1;        // Second pin pull-up allowed
	logic [1:0] req_flag;       // External request bits
	logic [1:0] trig_sel;       // External trigger bits
	logic       t0_irq;         // First overflow flag
	logic       t1_irq;         // Second overflow flag
	logic       baud;           // Baud tick pulse
	logic       irq;            // Masked status interrupt
	int         mismatches;     // Failed comparisons
	int         n_compared;     // All comparisons
	int         cyc;            // Cycle counter for the timeout

	// Free running clock, 50 ns period
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	dtc_cpu_model cpu (.clk(clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));

	// Clock enable is dropped once to show that counting freezes
	dtc_top #(.DIV(DIV)) DUT (.clk(clk), .rstn(rstn), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.first_timer_pin(pin0), .first_pin_drive(drv0),
		.first_pin_drive_en(drv0_en), .second_timer_pin(pin1),
		.second_pin_drive(drv1), .second_pin_drive_en(drv1_en),
		.second_pin_pullup_en(pullup1),
		.external_interrupt_pin(gate_pins),
		.external_request_flag(req_flag),
		.external_trigger_select(trig_sel), .first_timer_irq(t0_irq),
		.second_timer_irq(t1_irq), .baud_tick(baud), .irq(irq));

	// Counts, prints the verdict and ends the run
	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Byte compare
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Single output compare
	task automatic chk1(input logic g, input logic e);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Read a register and compare it
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] x;
		cpu.rd(a, x);
		chk8(x, e);
	endtask

	// Count advance across w+2 cycles between two read edges
	task automatic span(input logic [7:0] a, input int w,
		input logic [7:0] e);
		logic [7:0] x;
		logic [7:0] y;
		cpu.rd(a, x);
		repeat (w) @(posedge clk);
		cpu.rd(a, y);
		chk8(y - x, e);
	endtask

	// Bounded wait for a level or one-cycle pulse
	task automatic wait_ovf(input int sel);
		repeat (60) begin
			if ((sel == 0 ? t0_irq : sel == 1 ? t1_irq : baud) !== 1'b1)
			begin
				@(posedge clk);
				#1;
			end
		end
	endtask

	// Timeout: a hang counts as a mismatch
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			mismatches++;
			give_verdict();
		end
	end

	// Main sequence
	initial begin
		logic [7:0] x;
		logic [7:0] y;
		rstn = 1'b0;
		pin0 = 1'b1;
		pin1 = 1'b1;
		gate_pins = 2'h0;
		ce = 1'b1;
		mismatches = 0;
		n_compared = 0;
		cyc = 0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		#1;
		// Reset values, unmapped address and idle outputs
		for (int a = 8'h88; a <= 8'h8d; a++) rdc(8'(a), 8'h00);
		rdc(dtc_pkg::ADDR_PTC, 8'h00);
		rdc(8'h00, 8'h00);
		chk1(pullup1, 1'b1);
		chk1(drv0_en, 1'b0);
		$display("test reset done");
		// Plain bits of the control and prescale registers
		cpu.wr(dtc_pkg::ADDR_CTRL, 8'h0f);
		chk8({6'h00, req_flag, trig_sel}, 8'h0f);
		rdc(dtc_pkg::ADDR_CTRL, 8'h0f);
		cpu.wr(dtc_pkg::ADDR_PTC, 8'hf0);
		rdc(dtc_pkg::ADDR_PTC, 8'h00);
		$display("test registers done");
		// Prescale ratios, run and stop on a 16-bit count
		cpu.wr(dtc_pkg::ADDR_MODE, 8'h01);
		cpu.wr(dtc_pkg::ADDR_CTRL, 8'h10);
		span(dtc_pkg::ADDR_TL0, 118, 8'(120 / DIV));
		cpu.wr(dtc_pkg::ADDR_PTC, 8'h04);
		span(dtc_pkg::ADDR_TL0, 18, 8'h14);
		// Freeze: only the three enabled edges between the reads count
		cpu.rd(dtc_pkg::ADDR_TL0, x);
		@(posedge clk) ce <= 1'b0;
		repeat (20) @(posedge clk);
		ce <= 1'b1;
		cpu.rd(dtc_pkg::ADDR_TL0, y);
		chk8(y - x, 8'h03);
		cpu.wr(dtc_pkg::ADDR_CTRL, 8'h00);
		span(dtc_pkg::ADDR_TL0, 18, 8'h00);
		// Gate pin holds the count, then it resumes
		cpu.wr(dtc_pkg::ADDR_MODE, 8'h09);
		cpu.wr(dtc_pkg::ADDR_CTRL, 8'h10);
		span(dtc_pkg::ADDR_TL0, 18, 8'h00);
		@(posedge clk) gate_pins <= 2'h1;
		span(dtc_pkg::ADDR_TL0, 18, 8'h14);
		$display("test prescale and gate done");
		// Counter operation: five falling edges on the pin
		cpu.wr(dtc_pkg::ADDR_MODE, 8'h05);
		cpu.wr(dtc_pkg::ADDR_PTC, 8'h05);
		chk1(drv0_en, 1'b0);
		cpu.rd(dtc_pkg::ADDR_TL0, x);
		repeat (5) begin
			@(posedge clk) pin0 <= 1'b0;
			repeat (2) @(posedge clk);
			pin0 <= 1'b1;
			repeat (2) @(posedge clk);
		end
		cpu.rd(dtc_pkg::ADDR_TL0, y);
		chk8(y - x, 8'h05);
		$display("test counter done");
		// Auto-reload overflow, pin toggle and status interrupt
		cpu.wr(dtc_pkg::ADDR_CTRL, 8'h00);
		cpu.wr(dtc_pkg::ADDR_MODE, 8'h02);
		cpu.wr(dtc_pkg::ADDR_TH0, 8'h80);
		cpu.wr(dtc_pkg::ADDR_TL0, 8'hfe);
		cpu.rd(dtc_pkg::ADDR_STS, x);
		cpu.wr(dtc_pkg::ADDR_MSK, 8'h01);
		chk1(drv0_en, 1'b1);
		cpu.wr(dtc_pkg::ADDR_CTRL, 8'h10);
		wait_ovf(0);
		chk1(t0_irq, 1'b1);
		chk1(irq, 1'b1);
		chk1(drv0, 1'b1);
		cpu.wr(dtc_pkg::ADDR_CTRL, 8'h20);
		rdc(dtc_pkg::ADDR_TH0, 8'h80);
		rdc(dtc_pkg::ADDR_STS, 8'h01);
		chk1(irq, 1'b0);
		chk1(t0_irq, 1'b1);
		$display("test reload done");
		// Thirteen-bit mode: carry from five low bits, mask held off
		cpu.wr(dtc_pkg::ADDR_CTRL, 8'h00);
		cpu.wr(dtc_pkg::ADDR_MODE, 8'h00);
		cpu.wr(dtc_pkg::ADDR_MSK, 8'h00);
		cpu.wr(dtc_pkg::ADDR_TL0, 8'hff);
		cpu.wr(dtc_pkg::ADDR_TH0, 8'hff);
		cpu.wr(dtc_pkg::ADDR_CTRL, 8'h10);
		wait_ovf(0);
		chk1(t0_irq, 1'b1);
		chk1(irq, 1'b0);
		cpu.wr(dtc_pkg::ADDR_CTRL, 8'h20);
		rdc(dtc_pkg::ADDR_TH0, 8'h00);
		cpu.rd(dtc_pkg::ADDR_TL0, x);
		chk8(x & 8'he0, 8'he0);
		cpu.wr(dtc_pkg::ADDR_CTRL, 8'h80);
		chk1(t1_irq, 1'b1);
		$display("test mode zero done");
		// Split mode: high byte on second run bit, low byte alone
		cpu.wr(dtc_pkg::ADDR_CTRL, 8'h00);
		cpu.wr(dtc_pkg::ADDR_MODE, 8'h33);
		chk1(pullup1, 1'b0);
		cpu.wr(dtc_pkg::ADDR_TL0, 8'h42);
		cpu.wr(dtc_pkg::ADDR_TH0, 8'hf0);
		cpu.wr(dtc_pkg::ADDR_TL1, 8'h10);
		cpu.wr(dtc_pkg::ADDR_PTC, 8'h04);
		cpu.wr(dtc_pkg::ADDR_CTRL, 8'h40);
		wait_ovf(1);
		chk1(t1_irq, 1'b1);
		rdc(dtc_pkg::ADDR_TL0, 8'h42);
		rdc(dtc_pkg::ADDR_TL1, 8'h10);
		cpu.wr(dtc_pkg::ADDR_CTRL, 8'h10);
		span(dtc_pkg::ADDR_TL0, 18, 8'h14);
		// Split mode: second timer runs by mode, gate and pin ignored
		cpu.wr(dtc_pkg::ADDR_CTRL, 8'h00);
		@(posedge clk) gate_pins <= 2'h0;
		cpu.wr(dtc_pkg::ADDR_MODE, 8'hd3);
		cpu.wr(dtc_pkg::ADDR_TL1, 8'hf0);
		cpu.wr(dtc_pkg::ADDR_TH1, 8'hff);
		cpu.wr(dtc_pkg::ADDR_PTC, 8'h0a);
		chk1(drv1_en, 1'b1);
		wait_ovf(2);
		chk1(baud, 1'b1);
		chk1(drv1, 1'b1);
		chk1(t1_irq, 1'b0);
		cpu.wr(dtc_pkg::ADDR_MODE, 8'hf3);
		span(dtc_pkg::ADDR_TL1, 18, 8'h00);
		$display("test split done");
		give_verdict();
	end
endmodule
